/* verilog/eopc_pkg.sv */
// constants, register map and stream types of the encoder output and pedestal control
// ==============================================================
// Operation
// - converter power-down bits 7, 6, 5
// - bit 2 bypasses overlay table
// - bit 7 selects reference sync source
// - wide range: 0..2047, half resolution
// - normal range: saturate to 0..1023
// - bit 4 inserts inverse-sinc filter
// - bit 2 removes luma from composite
// - bit 1 removes chroma from composite
// - bit 0 suppresses colour burst
// - even vector: 0x14 high, 0x15 low
// - even bits 0..14 map lines 10..24
// - even bit 15 covers lines 25..263
// - odd vector 15 bits, 0x16 high
// - odd bits 0..13 map lines 273..286
// - odd bit 14 covers lines 287..525
// - odd bits 6..0 from 0x17[7:1]
package eopc_pkg;
  // ============================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_PWR   = 6'h10;
  localparam logic [5:0] IDX_PATH  = 6'h11;
  localparam logic [5:0] IDX_EVN_H = 6'h14;
  localparam logic [5:0] IDX_EVN_L = 6'h15;
  localparam logic [5:0] IDX_ODD_H = 6'h16;
  localparam logic [5:0] IDX_ODD_L = 6'h17;
  // ============================================================
  // field positions
  localparam int B_COMP_OFF = 7;
  localparam int B_CHRM_OFF = 6;
  localparam int B_LUMA_OFF = 5;
  localparam int B_OLUT_OFF = 2;
  localparam int B_REF_SEL  = 7;
  localparam int B_WIDE     = 5;
  localparam int B_SINC     = 4;
  localparam int B_LUMA_G   = 2;
  localparam int B_CHRM_G   = 1;
  localparam int B_BURST_G  = 0;
  localparam logic [7:0] PWR_MASK  = 8'hE4;
  localparam logic [7:0] PATH_MASK = 8'hB7;
  localparam logic [7:0] ODDL_MASK = 8'hFE;
  localparam logic [7:0] RST_VAL   = 8'h00;
  // ============================================================
  // line numbers of the pedestal windows
  localparam logic [9:0] E_FIRST = 10'h00A;
  localparam logic [9:0] E_LAST  = 10'h018;
  localparam logic [9:0] E_BODY  = 10'h019;
  localparam logic [9:0] E_END   = 10'h107;
  localparam logic [9:0] O_FIRST = 10'h111;
  localparam logic [9:0] O_LAST  = 10'h11E;
  localparam logic [9:0] O_BODY  = 10'h11F;
  localparam logic [9:0] O_END   = 10'h20D;
  // ============================================================
  // summer limits and pedestal level
  localparam logic signed [12:0] SUM_MAX  = 13'sh03FF;
  localparam logic signed [12:0] WIDE_MAX = 13'sh07FF;
  localparam logic signed [12:0] SUM_MIN  = 13'sh0000;
  localparam logic signed [12:0] PED_LVL  = 13'sh002C;
  localparam int SINC_SH    = 2;
  localparam int FIFO_DEPTH = 8;
  // overlay colour table, arbitrary contents
  localparam logic [7:0] OLUT [8] = '{8'h10, 8'h30, 8'h50, 8'h70,
                                       8'h90, 8'hB0, 8'hD0, 8'hF0};
  // ============================================================
  // stream words
  typedef struct packed {
    logic              field;
    logic [9:0]        line;
    logic [9:0]        luma;
    logic signed [9:0] chroma;
    logic signed [9:0] burst;
    logic [2:0]        overlay;
  } eopc_pix_t;
  typedef struct packed {
    logic [9:0] composite;
    logic       pedestal;
    logic [7:0] overlay;
  } eopc_vid_t;
endpackage : eopc_pkg

/* verilog/eopc_top.sv */
// output stage and pedestal control of the encoder, with its input fifo
// ==============================================================
// fifo with parameter width and depth
module eopc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid_i && in_ready_o;
  wire           pop  = out_valid_o && out_ready_i;
  // honest flags from the fill count
  assign in_ready_o  = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
  // pointers and count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= push ? AW'(wp_q + 1'b1) : wp_q;
      rp_q  <= pop ? AW'(rp_q + 1'b1) : rp_q;
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end
endmodule : eopc_fifo

// ==============================================================
// top: ahb-lite registers, pin sync, composite path
module eopc_top
  import eopc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  input  wire logic [9:0]  pixel_data_port_i,
  input  wire logic [9:0]  composite_video_input_i,
  output logic [7:0]       reference_sync_detector_o,
  output logic             composite_converter_off_o,
  output logic             chroma_converter_off_o,
  output logic             luma_converter_off_o,
  input  wire logic        pix_valid_i,
  output logic             pix_ready_o,
  input  wire eopc_pix_t   pix_i,
  output logic             vid_valid_o,
  input  wire logic        vid_ready_i,
  output eopc_vid_t        vid_o
);
  // ============================================================
  // register bus
  logic [7:0] pwr_q;
  logic [7:0] path_q;
  logic [7:0] evn_h_q;
  logic [7:0] evn_l_q;
  logic [7:0] odd_h_q;
  logic [7:0] odd_l_q;
  logic       wr_q;
  logic [5:0] idx_q;

  // address phase decode
  wire        acc_take = hsel_i && htrans_i[1] && hready_i;
  wire [7:0]  wbyte    = hwdata_i[7:0];
  wire        wr_pwr   = wr_q && (idx_q == IDX_PWR);
  wire        wr_path  = wr_q && (idx_q == IDX_PATH);
  wire        wr_evn_h = wr_q && (idx_q == IDX_EVN_H);
  wire        wr_evn_l = wr_q && (idx_q == IDX_EVN_L);
  wire        wr_odd_h = wr_q && (idx_q == IDX_ODD_H);
  wire        wr_odd_l = wr_q && (idx_q == IDX_ODD_L);

  // zero wait states, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // capture the address phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q  <= 1'b0;
      idx_q <= '0;
    end else begin
      wr_q  <= acc_take && hwrite_i;
      idx_q <= acc_take ? haddr_i[7:2] : idx_q;
    end
  end

  // data phase writes, reserved bits never stored
  // reserved bits ignored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_q   <= RST_VAL;
      path_q  <= RST_VAL;
      evn_h_q <= RST_VAL;
      evn_l_q <= RST_VAL;
      odd_h_q <= RST_VAL;
      odd_l_q <= RST_VAL;
    end else begin
      pwr_q   <= wr_pwr ? (wbyte & PWR_MASK) : pwr_q;
      path_q  <= wr_path ? (wbyte & PATH_MASK) : path_q;
      evn_h_q <= wr_evn_h ? wbyte : evn_h_q;
      evn_l_q <= wr_evn_l ? wbyte : evn_l_q;
      odd_h_q <= wr_odd_h ? wbyte : odd_h_q;
      odd_l_q <= wr_odd_l ? (wbyte & ODDL_MASK) : odd_l_q;
    end
  end

  // read mux, unmapped reads zero
  wire [7:0] rd_byte =
    (idx_q == IDX_PWR)   ? pwr_q   :
    (idx_q == IDX_PATH)  ? path_q  :
    (idx_q == IDX_EVN_H) ? evn_h_q :
    (idx_q == IDX_EVN_L) ? evn_l_q :
    (idx_q == IDX_ODD_H) ? odd_h_q :
    (idx_q == IDX_ODD_L) ? odd_l_q : 8'h00;
  assign hrdata_o = {24'h000000, rd_byte};

  // ============================================================
  // control fields
  wire        wide_range  = path_q[B_WIDE];
  wire        sinc_on     = path_q[B_SINC];
  wire        luma_gate   = path_q[B_LUMA_G];
  wire        chroma_gate = path_q[B_CHRM_G];
  wire        burst_gate  = path_q[B_BURST_G];
  wire        olut_off    = pwr_q[B_OLUT_OFF];
  wire [15:0] even_pedestal_vector = {evn_h_q, evn_l_q};
  wire [14:0] odd_pedestal_vector  = {odd_h_q, odd_l_q[7:1]};

  assign composite_converter_off_o = pwr_q[B_COMP_OFF];
  assign chroma_converter_off_o    = pwr_q[B_CHRM_OFF];
  assign luma_converter_off_o      = pwr_q[B_LUMA_OFF];

  // ============================================================
  // pin synchronisers for the sync detector sources
  logic [9:0] pd_s1_q;
  logic [9:0] pd_s2_q;
  logic [9:0] cv_s1_q;
  logic [9:0] cv_s2_q;
  logic [7:0] drs_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_s1_q <= '0;
      pd_s2_q <= '0;
      cv_s1_q <= '0;
      cv_s2_q <= '0;
    end else begin
      pd_s1_q <= pixel_data_port_i;
      pd_s2_q <= pd_s1_q;
      cv_s1_q <= composite_video_input_i;
      cv_s2_q <= cv_s1_q;
    end
  end

  wire [7:0] drs_d = path_q[B_REF_SEL] ? pd_s2_q[7:0] : cv_s2_q[9:2];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drs_q <= '0;
    end else begin
      drs_q <= drs_d;
    end
  end
  assign reference_sync_detector_o = drs_q;

  // ============================================================
  // input fifo
  eopc_pix_t fifo_data;
  logic      fifo_valid;
  logic      vid_valid_q;
  eopc_vid_t vid_q;
  wire       pop = fifo_valid && (!vid_valid_q || vid_ready_i);

  eopc_fifo #(.W($bits(eopc_pix_t)), .D(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pix_valid_i),
    .in_ready_o  (pix_ready_o),
    .in_data_i   (pix_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_data)
  );

  // ============================================================
  // pedestal line decode
  wire [9:0] ln      = fifo_data.line;
  wire [9:0] e_off   = 10'(ln - E_FIRST);
  wire [9:0] o_off   = 10'(ln - O_FIRST);
  wire       e_line  = (ln >= E_FIRST) && (ln <= E_LAST) && even_pedestal_vector[e_off[3:0]];
  wire       e_body  = (ln >= E_BODY) && (ln <= E_END) && even_pedestal_vector[15];
  wire       o_line  = (ln >= O_FIRST) && (ln <= O_LAST) && odd_pedestal_vector[o_off[3:0]];
  wire       o_body  = (ln >= O_BODY) && (ln <= O_END) && odd_pedestal_vector[14];
  wire       ped_on  = fifo_data.field ? (o_line || o_body) : (e_line || e_body);

  // ============================================================
  // composite summer
  // luma, chroma and burst gates, pedestal level
  wire signed [12:0] luma_t = luma_gate ? 13'sh0000 : $signed({3'b000, fifo_data.luma});
  wire signed [12:0] chr_t  = chroma_gate ? 13'sh0000 : 13'(fifo_data.chroma);
  wire signed [12:0] bst_t  = burst_gate ? 13'sh0000 : 13'(fifo_data.burst);
  wire signed [12:0] ped_t  = ped_on ? PED_LVL : 13'sh0000;
  wire signed [12:0] sum    = 13'(luma_t + chr_t + bst_t + ped_t);

  // inverse-sinc peaking on the composite sum
  logic signed [12:0] prev_q;
  wire signed [12:0]  diff  = 13'(sum - prev_q);
  wire signed [12:0]  peak  = 13'(sum + (diff >>> SINC_SH));
  wire signed [12:0]  filt  = sinc_on ? peak : sum;

  wire signed [12:0]  wlim  = (filt > WIDE_MAX) ? WIDE_MAX :
                              (filt < SUM_MIN) ? SUM_MIN : filt;
  wire signed [12:0]  nlim  = (filt > SUM_MAX) ? SUM_MAX :
                              (filt < SUM_MIN) ? SUM_MIN : filt;
  wire [9:0]          comp  = wide_range ? wlim[10:1] : nlim[9:0];

  wire [7:0] ovl = olut_off ? {fifo_data.overlay, 5'h00} : OLUT[fifo_data.overlay];

  // output register and filter history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vid_valid_q <= 1'b0;
      vid_q       <= '0;
      prev_q      <= '0;
    end else begin
      vid_valid_q <= pop ? 1'b1 : (vid_ready_i ? 1'b0 : vid_valid_q);
      vid_q       <= pop ? '{composite: comp, pedestal: ped_on, overlay: ovl} : vid_q;
      prev_q      <= pop ? sum : prev_q;
    end
  end
  assign vid_valid_o = vid_valid_q;
  assign vid_o       = vid_q;

  // ============================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pwr_write;
    acc_take && hwrite_i && (haddr_i[7:2] == IDX_PWR) ##1 1'b1;
  endsequence

  chk_dac_power: assert property (s_pwr_write |=>
    composite_converter_off_o == $past(hwdata_i[7]) &&
    chroma_converter_off_o == $past(hwdata_i[6]) &&
    luma_converter_off_o == $past(hwdata_i[5]))
    else $error("converter power bits wrong after write");

  chk_drs_route: assert property (
    $stable(path_q) [*4] ##0 !$past(rst_i, 3) |-> reference_sync_detector_o ==
    (path_q[7] ? $past(pixel_data_port_i[7:0], 3) : $past(composite_video_input_i[9:2], 3)))
    else $error("sync detector source wrong");

  chk_sum_limit: assert property (pop && !wide_range && filt > SUM_MAX |=>
    vid_o.composite == 10'h3FF)
    else $error("summer not saturated high");

  chk_wide_half: assert property (pop && wide_range && filt >= 0 && filt <= WIDE_MAX |=>
    vid_o.composite == $past(filt[10:1]))
    else $error("wide range output wrong");

  chk_even_body: assert property (pop && !fifo_data.field && ln == E_END |=>
    vid_o.pedestal == $past(evn_h_q[7]))
    else $error("even body pedestal wrong");

  chk_even_first: assert property (pop && !fifo_data.field && ln == E_FIRST |=>
    vid_o.pedestal == $past(evn_l_q[0]))
    else $error("even line pedestal wrong");

  chk_odd_first: assert property (pop && fifo_data.field && ln == O_FIRST |=>
    vid_o.pedestal == $past(odd_l_q[1]))
    else $error("odd line pedestal wrong");

  chk_ped_outside: assert property (pop && ln < E_FIRST |=> !vid_o.pedestal)
    else $error("pedestal outside window");

  chk_all_gated: assert property (pop && luma_gate && chroma_gate && burst_gate &&
    !ped_on && !sinc_on |=> vid_o.composite == 10'h000)
    else $error("gated composite not zero");

  chk_olut_bypass: assert property (pop && olut_off |=>
    vid_o.overlay == {$past(fifo_data.overlay), 5'h00})
    else $error("overlay bypass wrong");

  chk_even_low: assert property (wr_evn_l |=> evn_l_q == $past(wbyte))
    else $error("even low byte not stored");

  chk_odd_high: assert property (wr_odd_h |=> odd_h_q == $past(wbyte))
    else $error("odd high byte not stored");

  // held output stays
  chk_out_hold: assert property (vid_valid_o && !vid_ready_i |=> $stable(vid_o) && vid_valid_o)
    else $error("output changed while stalled");
endmodule : eopc_top

/* verif/testbench.sv */
// self-checking bench for the encoder output and pedestal control
module testbench import eopc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hsel, hwrite, hreadyout, hresp, pix_valid, pix_ready, vid_valid, vid_ready;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [9:0]  pd, cv;
  logic [7:0]  rsd;
  logic [2:0]  offs;
  eopc_pix_t   pix;
  eopc_vid_t   vid;
  eopc_vid_t   exp_q[$];
  logic [7:0]  sh[8];
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          prev = 0;
  int          n;
  logic        r;
  // test tables
  logic [7:0]  pm[8] = '{8'h00, 8'h04, 8'h02, 8'h01, 8'h20, 8'h10, 8'h30, 8'h07};
  int          lu[3] = '{1000, 10, 500};
  int          ch[3] = '{100, -200, 30};
  int          bu[3] = '{20, 0, -10};
  int          ln[15] = '{9, 10, 11, 24, 25, 263, 264, 272, 273, 274, 279, 280, 286, 287, 525};
  logic [5:0]  ri[8] = '{6'h10, 6'h11, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h12};
  // ============================================================
  // clock and design
  always #2.5 clk_i = ~clk_i;
  eopc_top u_eopc_top (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .pixel_data_port_i(pd), .composite_video_input_i(cv), .reference_sync_detector_o(rsd),
    .composite_converter_off_o(offs[2]), .chroma_converter_off_o(offs[1]),
    .luma_converter_off_o(offs[0]), .pix_valid_i(pix_valid), .pix_ready_o(pix_ready),
    .pix_i(pix), .vid_valid_o(vid_valid), .vid_ready_i(vid_ready), .vid_o(vid));
  // ============================================================
  // compare and report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      print_verdict();
    end
  end
  // ============================================================
  // ahb-lite single word transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    logic ok;
    @(posedge clk_i);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
    haddr <= {24'h000000, idx, 2'b00};
    do begin @(negedge clk_i); ok = hreadyout; @(posedge clk_i); end while (ok !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= {24'h000000, d};
    do begin
      @(negedge clk_i); ok = hreadyout; rdv = hrdata; @(posedge clk_i);
    end while (ok !== 1'b1);
  endtask : bus
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
    if (idx == IDX_PWR) sh[0] = d & PWR_MASK;
    else if (idx == IDX_PATH) sh[1] = d & PATH_MASK;
    else if (idx == IDX_ODD_L) sh[7] = d & ODDL_MASK;
    else if (idx inside {IDX_EVN_H, IDX_EVN_L, IDX_ODD_H}) sh[idx[2:0]] = d;
  endtask : wr
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    check(rdv, {24'h000000, e});
  endtask : rd_chk
  // ============================================================
  // expected output word from the shadow registers
  function automatic logic ped(logic f, int l);
    logic [15:0] ev;
    logic [14:0] od;
    ev = {sh[4], sh[5]};
    od = {sh[6], sh[7][7:1]};
    if (!f && l >= 10 && l <= 24) return ev[l-10];
    if (!f && l >= 25 && l <= 263) return ev[15];
    if (f && l >= 273 && l <= 286) return od[l-273];
    if (f && l >= 287 && l <= 525) return od[14];
    return 1'b0;
  endfunction : ped
  function automatic eopc_vid_t expv(eopc_pix_t p);
    eopc_vid_t v;
    int s, fv, top;
    v.pedestal = ped(p.field, int'(p.line));
    s = (sh[1][2] ? 0 : int'(p.luma)) + (sh[1][1] ? 0 : int'($signed(p.chroma)))
      + (sh[1][0] ? 0 : int'($signed(p.burst))) + (v.pedestal ? 44 : 0);
    fv = sh[1][4] ? s + ((s - prev) >>> 2) : s;
    prev = s;
    top = sh[1][5] ? 2047 : 1023;
    fv = (fv > top) ? top : (fv < 0) ? 0 : fv;
    v.composite = sh[1][5] ? 10'(fv >> 1) : 10'(fv);
    v.overlay = sh[0][2] ? {p.overlay, 5'b00000} : OLUT[p.overlay];
    return v;
  endfunction : expv
  function automatic eopc_pix_t px(logic f, int l, int y, int c, int b, int o);
    return {f, 10'(l), 10'(y), 10'(c), 10'(b), 3'(o)};
  endfunction : px
  // ============================================================
  // stream push, output collector and drain
  task automatic push(input eopc_pix_t w);
    logic ok;
    exp_q.push_back(expv(w));
    @(posedge clk_i);
    pix <= w; pix_valid <= 1'b1;
    do begin @(negedge clk_i); ok = pix_ready; @(posedge clk_i); end while (ok !== 1'b1);
    pix_valid <= 1'b0;
  endtask : push
  always @(negedge clk_i) begin
    if (vid_valid === 1'b1 && vid_ready === 1'b1) begin
      if (exp_q.size() == 0) check(32'h0, 32'h1);
      else check(32'(vid), 32'(exp_q.pop_front()));
    end
  end
  task automatic drain;
    for (int i = 0; i < 60 && exp_q.size() != 0; i++) @(posedge clk_i);
    check(32'(exp_q.size()), 32'h0);
  endtask : drain
  // ============================================================
  // main sequence
  initial begin
    hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0; hwdata = 0;
    pix_valid = 0; vid_ready = 1; pix = '0; pd = 10'h2AB; cv = 10'h3C5;
    sh = '{default: 8'h00};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and two unmapped places
    foreach (ri[i]) rd_chk(ri[i], 8'h00);
    check(32'(hresp), 32'h0);
    // software keeps reserved bits at zero
    wr(IDX_PWR, PWR_MASK);
    rd_chk(IDX_PWR, PWR_MASK);
    check(32'(offs), 32'h7);
    wr(IDX_PWR, 8'hA0);
    @(negedge clk_i);
    check(32'(offs), 32'h5);
    wr(IDX_PATH, PATH_MASK);
    rd_chk(IDX_PATH, PATH_MASK);
    wr(6'h12, 8'h5A);
    rd_chk(6'h12, 8'h00);
    // reference sync source
    wr(IDX_PATH, 8'h80);
    repeat (6) @(posedge clk_i);
    check(32'(rsd), 32'h000000AB);
    wr(IDX_PATH, 8'h00);
    repeat (6) @(posedge clk_i);
    check(32'(rsd), 32'h000000F1);
    // pedestal vectors at their line boundaries
    wr(IDX_EVN_H, 8'hC0);
    wr(IDX_EVN_L, 8'h01);
    wr(IDX_ODD_H, 8'h81);
    wr(IDX_ODD_L, 8'h83);
    rd_chk(IDX_ODD_L, 8'h82);
    rd_chk(IDX_EVN_H, 8'hC0);
    rd_chk(IDX_ODD_H, 8'h81);
    foreach (ln[i]) push(px(i > 6, ln[i], 100, 0, 0, 1));
    push(px(1'b0, 263, 100, 0, 0, 2));
    push(px(1'b1, 24, 100, 0, 0, 2));
    drain();
    // composite modes, gates and overlay bypass
    foreach (pm[i]) begin
      wr(IDX_PATH, pm[i]);
      wr(IDX_PWR, i[0] ? 8'h04 : 8'h00);
      for (int j = 0; j < 3; j++) push(px(1'b0, 5, lu[j], ch[j], bu[j], i + j));
      drain();
    end
    // fill the input buffer with the output stalled
    @(posedge clk_i);
    vid_ready <= 1'b0;
    pix_valid <= 1'b1;
    pix <= px(1'b0, 5, 0, 0, 0, 0);
    n = 0;
    do begin
      @(negedge clk_i); r = pix_ready; @(posedge clk_i);
      if (r === 1'b1) begin
        exp_q.push_back(expv(pix));
        n++;
        pix <= px(1'b0, 5, n * 7, 0, 0, n);
      end
    end while (r === 1'b1 && n < 20);
    pix_valid <= 1'b0;
    check(32'(n), 32'h9);
    // drain with a stalling receiver
    repeat (40) @(posedge clk_i) vid_ready <= ~vid_ready;
    vid_ready <= 1'b1;
    drain();
    print_verdict();
  end
endmodule : testbench
